// ===== include/rcd_map.svh
`ifndef RCD_MAP_SVH
`define RCD_MAP_SVH

// ============================================================
// Opcode encodings.
`define RCD_OPC_REG_READ    3'h0
`define RCD_OPC_REG_WRITE   3'h1
`define RCD_OPC_RX_READ     8'h61
`define RCD_OPC_TX_WRITE    8'hA0
`define RCD_OPC_TX_FLUSH    8'hE1
`define RCD_OPC_RX_FLUSH    8'hE2
`define RCD_OPC_REPEAT      8'hE3
`define RCD_OPC_WIDTH       8'h60
`define RCD_OPC_ACK_WRITE   5'h15
`define RCD_OPC_TX_NOACK    8'hB0
`define RCD_OPC_IDLE        8'hFF

// ============================================================
// Sizes and limits.
`define RCD_MAX_PAYLOAD     6'h20
`define RCD_MAX_REG_BYTES   6'h05
`define RCD_MAX_ACK         2'h3
`define RCD_PIPE_LAST       3'h5
`define RCD_LAST_BIT        3'h7
`define RCD_CNT_W           6
`define RCD_ADDR_W          5

`endif

// ===== include/rcd_pkg.sv
`default_nettype none
`include "rcd_map.svh"

package rcd_pkg;

    // ============================================================
    // Decoded command kinds.
    typedef enum logic [3:0] {
        CMD_NONE  = 4'h0,
        CMD_RREG  = 4'h1,
        CMD_WREG  = 4'h2,
        CMD_RXRD  = 4'h3,
        CMD_TXWR  = 4'h4,
        CMD_TXNA  = 4'h5,
        CMD_ACKW  = 4'h6,
        CMD_FLTX  = 4'h7,
        CMD_FLRX  = 4'h8,
        CMD_REUSE = 4'h9,
        CMD_WIDQ  = 4'hA,
        CMD_IDLE  = 4'hB
    } rcd_cmd_t;

    // ============================================================
    // Whole state of the decoder.
    typedef struct packed {
        logic                       sck_q;
        logic                       cs_q;
        logic                       first;
        logic [2:0]                 bitcnt;
        logic [7:0]                 sh_in;
        logic [7:0]                 sh_out;
        rcd_cmd_t                   cmd;
        logic [`RCD_CNT_W-1:0]      nbytes;
        logic [4:0]                 reg_addr;
        logic [2:0]                 ack_pipe;
        logic [1:0]                 ack_cnt;
        logic                       reuse;
        logic                       tx_commit;
        logic                       tx_no_ack;
        logic                       tx_flush;
        logic                       rx_flush;
        logic                       rx_pop;
        logic                       ack_commit;
        logic                       reg_wr;
        logic [7:0]                 reg_wdata;
        logic [`RCD_CNT_W-1:0]      len;
    } rcd_state_t;

endpackage

`default_nettype wire

// ===== include/rcd_mem_if.sv
`timescale 1ns/100ps
`default_nettype none
`include "rcd_map.svh"

// ============================================================
// Staging memory port: write from the decoder, read by the radio core.
interface rcd_mem_if;
    logic                   we;
    logic [`RCD_ADDR_W-1:0] waddr;
    logic [7:0]             wdata;
    logic [`RCD_ADDR_W-1:0] raddr;
    logic [7:0]             rdata;

    modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

`default_nettype wire

// ===== rtl/rcd_mem.sv
`timescale 1ns/100ps
`default_nettype none

// ============================================================
// Payload staging memory with registered read data.
module rcd_mem #(
    parameter int DEPTH = 32
) (
    input  wire logic i_ref_clk,
    rcd_mem_if.mem    port
);

    logic [7:0] mem_q [DEPTH];

    // Write one byte and register the read byte every cycle.
    always_ff @(posedge i_ref_clk) begin
        if (port.we) begin
            mem_q[port.waddr] <= port.wdata;
        end
        port.rdata <= mem_q[port.raddr];
    end

endmodule

`default_nettype wire

// ===== rtl/rcd_decoder.sv
// How it works
// - Receive read shifts out payload bytes from index zero, pops payload at frame end.
// - Transmit write stores 1 to 32 bytes from index zero, then queues them.
// - Transmit flush has no data and empties the transmit queue.
// - Receive flush has no data and empties the receive queue.
// - Repeat command makes the transmitter resend its last payload.
// - Repeating ends on a transmit write or a transmit flush.
// - Width query returns the byte count of the head receive payload.
// - Acknowledge write stores 1 to 32 bytes for the selected pipe.
// - Only pipe selectors zero through five are accepted.
// - At most three acknowledge payloads wait at once.
// - Acknowledge payloads leave in the order written.
// - No-acknowledge write sends its packet without automatic acknowledge.
// - Idle opcode changes nothing; only the status byte shifts out.
// - Register opcodes carry a five-bit address and 1 to 5 data bytes.
`timescale 1ns/100ps
`default_nettype none
`include "rcd_map.svh"

module rcd_decoder #(
    parameter int DEPTH = 32
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_arst_n,
    input  wire logic        i_spi_sck,
    input  wire logic        i_spi_cs_n,
    input  wire logic        i_spi_mosi,
    output logic             o_spi_miso,
    output logic             o_spi_miso_oe,
    input  wire logic [7:0]  i_status,
    input  wire logic [7:0]  i_rx_byte,
    input  wire logic [7:0]  i_rx_width,
    input  wire logic [7:0]  i_reg_rdata,
    input  wire logic        i_ack_sent,
    input  wire logic [4:0]  i_stage_raddr,
    output logic [7:0]       o_stage_rdata,
    output logic [5:0]       o_rx_idx,
    output logic             o_rx_pop,
    output logic             o_rx_flush,
    output logic             o_tx_commit,
    output logic             o_tx_no_ack,
    output logic             o_tx_flush,
    output logic [5:0]       o_len,
    output logic             o_reuse_active,
    output logic             o_ack_commit,
    output logic [2:0]       o_ack_pipe,
    output logic [4:0]       o_reg_addr,
    output logic [5:0]       o_reg_byte,
    output logic             o_reg_wr,
    output logic [7:0]       o_reg_wdata
);

    rcd_pkg::rcd_state_t r_reg;
    rcd_pkg::rcd_state_t r_next;
    rcd_mem_if           mif ();

    // ============================================================
    // Opcode decode.
    function automatic rcd_pkg::rcd_cmd_t decode(input logic [7:0] opc);
        rcd_pkg::rcd_cmd_t c;
        c = rcd_pkg::CMD_NONE;
        if (opc[7:5] == `RCD_OPC_REG_READ) begin
            c = rcd_pkg::CMD_RREG;
        end else if (opc[7:5] == `RCD_OPC_REG_WRITE) begin
            c = rcd_pkg::CMD_WREG;
        end else if (opc[7:3] == `RCD_OPC_ACK_WRITE) begin
            if (opc[2:0] <= `RCD_PIPE_LAST) begin
                c = rcd_pkg::CMD_ACKW;
            end
        end else begin
            case (opc)
                `RCD_OPC_RX_READ:  c = rcd_pkg::CMD_RXRD;
                `RCD_OPC_TX_WRITE: c = rcd_pkg::CMD_TXWR;
                `RCD_OPC_TX_NOACK: c = rcd_pkg::CMD_TXNA;
                `RCD_OPC_TX_FLUSH: c = rcd_pkg::CMD_FLTX;
                `RCD_OPC_RX_FLUSH: c = rcd_pkg::CMD_FLRX;
                `RCD_OPC_REPEAT:   c = rcd_pkg::CMD_REUSE;
                `RCD_OPC_WIDTH:    c = rcd_pkg::CMD_WIDQ;
                `RCD_OPC_IDLE:     c = rcd_pkg::CMD_IDLE;
                default:           c = rcd_pkg::CMD_NONE;
            endcase
        end
        return c;
    endfunction

    // ============================================================
    // Byte to shift out after each completed byte.
    function automatic logic [7:0] out_byte(input rcd_pkg::rcd_state_t s, input logic [7:0] rxb,
                                            input logic [7:0] wid, input logic [7:0] regd);
        logic [7:0] b;
        b = 8'h00;
        case (s.cmd)
            rcd_pkg::CMD_RXRD: b = rxb;
            rcd_pkg::CMD_RREG: b = regd;
            rcd_pkg::CMD_WIDQ: b = (s.nbytes == '0) ? wid : 8'h00;
            default:           b = 8'h00;
        endcase
        return b;
    endfunction

    // ============================================================
    // Next-state logic.
    always_comb begin
        logic       rise;
        logic       fall;
        logic [7:0] sh;
        rise = i_spi_sck & ~r_reg.sck_q;
        fall = ~i_spi_sck & r_reg.sck_q;
        sh = {r_reg.sh_in[6:0], i_spi_mosi};
        r_next = r_reg;
        r_next.sck_q = i_spi_sck;
        r_next.cs_q = i_spi_cs_n;
        r_next.tx_commit = 1'b0;
        r_next.tx_flush = 1'b0;
        r_next.rx_flush = 1'b0;
        r_next.rx_pop = 1'b0;
        r_next.ack_commit = 1'b0;
        r_next.reg_wr = 1'b0;
        mif.we = 1'b0;
        mif.waddr = r_reg.nbytes[`RCD_ADDR_W-1:0];
        mif.wdata = sh;
        mif.raddr = i_stage_raddr;
        // A sent acknowledge frees one slot.
        if (i_ack_sent && r_reg.ack_cnt != 2'h0) begin
            r_next.ack_cnt = r_reg.ack_cnt - 2'h1;
        end
        if (!i_spi_cs_n && r_reg.cs_q) begin
            // Frame start: status byte is loaded first.
            r_next.cmd = rcd_pkg::CMD_NONE;
            r_next.first = 1'b1;
            r_next.bitcnt = 3'h0;
            r_next.nbytes = '0;
            r_next.sh_out = i_status;
        end else if (!i_spi_cs_n) begin
            if (rise) begin
                r_next.sh_in = sh;
                r_next.bitcnt = 3'(r_reg.bitcnt + 3'h1);
                if (r_reg.bitcnt == `RCD_LAST_BIT && r_reg.first) begin
                    r_next.first = 1'b0;
                    r_next.cmd = decode(sh);
                    r_next.reg_addr = sh[4:0];
                    r_next.ack_pipe = sh[2:0];
                end else if (r_reg.bitcnt == `RCD_LAST_BIT && r_reg.nbytes < `RCD_MAX_PAYLOAD) begin
                    // Data byte: first byte lands at index zero.
                    r_next.nbytes = r_reg.nbytes + 6'h01;
                    case (r_reg.cmd)
                        rcd_pkg::CMD_TXWR, rcd_pkg::CMD_TXNA, rcd_pkg::CMD_ACKW: begin
                            mif.we = 1'b1;
                        end
                        rcd_pkg::CMD_WREG: begin
                            r_next.reg_wr = (r_reg.nbytes < `RCD_MAX_REG_BYTES);
                            r_next.reg_wdata = sh;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            if (fall) begin
                r_next.sh_out = (r_reg.bitcnt == 3'h0) ?
                    out_byte(r_reg, i_rx_byte, i_rx_width, i_reg_rdata) : {r_reg.sh_out[6:0], 1'b0};
            end
        end else if (i_spi_cs_n && !r_reg.cs_q) begin
            // Frame end: side effects of the finished command.
            r_next.len = r_reg.nbytes;
            case (r_reg.cmd)
                rcd_pkg::CMD_RXRD: r_next.rx_pop = (r_reg.nbytes != '0);
                rcd_pkg::CMD_TXWR, rcd_pkg::CMD_TXNA: begin
                    if (r_reg.nbytes != '0) begin
                        r_next.tx_commit = 1'b1;
                        r_next.tx_no_ack = (r_reg.cmd == rcd_pkg::CMD_TXNA);
                        r_next.reuse = 1'b0;
                    end
                end
                rcd_pkg::CMD_ACKW: begin
                    // Commits go out in write order; the radio core keeps them in order.
                    if (r_reg.nbytes != '0 && r_next.ack_cnt < `RCD_MAX_ACK) begin
                        r_next.ack_commit = 1'b1;
                        r_next.ack_cnt = r_next.ack_cnt + 2'h1;
                    end
                end
                rcd_pkg::CMD_FLTX: begin
                    r_next.tx_flush = 1'b1;
                    r_next.reuse = 1'b0;
                    r_next.ack_cnt = 2'h0;
                end
                rcd_pkg::CMD_FLRX: r_next.rx_flush = 1'b1;
                rcd_pkg::CMD_REUSE: r_next.reuse = 1'b1;
                default: begin
                end
            endcase
        end
    end

    // ============================================================
    // State register.
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            r_reg <= '{sck_q: 1'b0, cs_q: 1'b1, cmd: rcd_pkg::CMD_NONE, default: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    rcd_mem #(
        .DEPTH (DEPTH)
    ) u_mem (
        .i_ref_clk (i_ref_clk),
        .port      (mif.mem)
    );

    // ============================================================
    // Outputs.
    assign o_spi_miso = r_reg.sh_out[7];
    assign o_spi_miso_oe = ~r_reg.cs_q;
    assign o_stage_rdata = mif.rdata;
    assign o_rx_idx = r_reg.nbytes;
    assign o_rx_pop = r_reg.rx_pop;
    assign o_rx_flush = r_reg.rx_flush;
    assign o_tx_commit = r_reg.tx_commit;
    assign o_tx_no_ack = r_reg.tx_no_ack;
    assign o_tx_flush = r_reg.tx_flush;
    assign o_len = r_reg.len;
    assign o_reuse_active = r_reg.reuse;
    assign o_ack_commit = r_reg.ack_commit;
    assign o_ack_pipe = r_reg.ack_pipe;
    assign o_reg_addr = r_reg.reg_addr;
    assign o_reg_byte = r_reg.nbytes;
    assign o_reg_wr = r_reg.reg_wr;
    assign o_reg_wdata = r_reg.reg_wdata;

    // ============================================================
    // Checks.
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);

    a_rx_pop_cause: assert property (o_rx_pop |->
        $past(r_reg.cmd) == rcd_pkg::CMD_RXRD && o_len != '0)
        else $error("rx pop without a receive read");
    a_tx_commit_len: assert property (o_tx_commit |-> o_len != '0 && o_len <= `RCD_MAX_PAYLOAD)
        else $error("tx commit length out of range");
    a_tx_flush_ends: assert property (o_tx_flush |->
        !o_reuse_active && $past(r_reg.cmd) == rcd_pkg::CMD_FLTX)
        else $error("tx flush did not end repeat mode");
    a_rx_flush_cause: assert property (o_rx_flush |-> $past(r_reg.cmd) == rcd_pkg::CMD_FLRX)
        else $error("rx flush without its command");
    a_reuse_rise: assert property ($rose(o_reuse_active) |-> $past(r_reg.cmd) == rcd_pkg::CMD_REUSE)
        else $error("repeat mode set without repeat command");
    a_reuse_end: assert property (o_tx_commit |-> !o_reuse_active)
        else $error("tx write left repeat mode on");
    a_ack_pipe_ok: assert property (o_ack_commit |-> o_ack_pipe <= `RCD_PIPE_LAST)
        else $error("ack commit on invalid pipe");
    a_ack_limit: assert property (r_reg.ack_cnt <= `RCD_MAX_ACK &&
        !(o_ack_commit && $past(r_reg.ack_cnt) == `RCD_MAX_ACK && !$past(i_ack_sent)))
        else $error("fourth ack payload accepted");
    a_noack_flag: assert property (o_tx_commit |->
        o_tx_no_ack == ($past(r_reg.cmd) == rcd_pkg::CMD_TXNA))
        else $error("no-ack flag does not match command");
    // The frame-end pulses stand in the very cycle in which the select rise shows in cs_q.
    a_idle_quiet: assert property ($rose(r_reg.cs_q) && $past(r_reg.cmd) == rcd_pkg::CMD_IDLE |->
        !o_tx_commit && !o_tx_flush && !o_rx_flush && !o_rx_pop && !o_ack_commit && $stable(o_reuse_active))
        else $error("idle opcode caused a side effect");
    a_unknown_quiet: assert property ($rose(r_reg.cs_q) && $past(r_reg.cmd) == rcd_pkg::CMD_NONE |->
        !o_tx_commit && !o_tx_flush && !o_rx_flush && !o_rx_pop && !o_ack_commit)
        else $error("unknown opcode caused a side effect");

endmodule

`default_nettype wire

// ===== tb/rcd_host.sv
`timescale 1ns/100ps
`default_nettype none

// ============================================================
// Host model: SPI mode 0 master sending one command per frame.
module rcd_host (
    input  wire logic i_ref_clk,
    input  wire logic i_spi_miso,
    output logic      o_sck,
    output logic      o_cs_n,
    output logic      o_mosi
);
    logic [7:0] tx_buf [0:39];
    logic [7:0] rx_buf [0:39];

    // Idle data line toggles so that a stale bit never passes for data.
    always @(negedge i_ref_clk) begin
        if (o_cs_n) o_mosi <= ~o_mosi;
    end

    // Clock stands low and select stands high outside frames.
    initial begin
        o_sck  = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end

    // One frame: opcode first, then data bytes from index zero, MSB first.
    task automatic xfer(input int n); // Sends n bytes in one select frame.
        @(negedge i_ref_clk) o_cs_n = 1'b0;
        repeat (2) @(negedge i_ref_clk);
        for (int i = 0; i < n; i++) begin
            for (int b = 7; b >= 0; b--) begin
                o_mosi = tx_buf[i][b];
                repeat (3) @(negedge i_ref_clk);
                o_sck = 1'b1;
                rx_buf[i][b] = i_spi_miso;
                repeat (3) @(negedge i_ref_clk);
                o_sck = 1'b0;
            end
        end
        repeat (3) @(negedge i_ref_clk);
        o_cs_n = 1'b1;
        repeat (6) @(negedge i_ref_clk);
    endtask
endmodule

`default_nettype wire

// ===== tb/test_radio_serial_command_decoder.sv
`timescale 1ns/100ps
`default_nettype none

// ============================================================
// Self-checking bench for the serial command decoder.
module test_radio_serial_command_decoder;
    logic        i_ref_clk, i_arst_n, i_spi_sck, i_spi_cs_n, i_spi_mosi, o_spi_miso, o_spi_miso_oe, i_ack_sent;
    logic [7:0]  i_status, i_rx_byte, i_rx_width, i_reg_rdata, o_stage_rdata, o_reg_wdata, c_wd, rx_base, reg_base;
    logic [5:0]  o_rx_idx, o_len, o_reg_byte, c_len;
    logic [4:0]  i_stage_raddr, o_reg_addr, c_ra;
    logic [2:0]  o_ack_pipe, c_pipe;
    logic        o_rx_pop, o_rx_flush, o_tx_commit, o_tx_no_ack, o_tx_flush, o_reuse_active, o_ack_commit;
    logic        o_reg_wr, c_na;
    logic [7:0]  pk [0:39];
    logic [31:0] seed;
    int          n_fail, n_checks, n_tx, n_rxp, n_ftx, n_frx, n_ack, n_reg, n_oe, n;

    rcd_decoder dut (.i_ref_clk, .i_arst_n, .i_spi_sck, .i_spi_cs_n, .i_spi_mosi, .o_spi_miso, .o_spi_miso_oe,
        .i_status, .i_rx_byte, .i_rx_width, .i_reg_rdata, .i_ack_sent, .i_stage_raddr, .o_stage_rdata,
        .o_rx_idx, .o_rx_pop, .o_rx_flush, .o_tx_commit, .o_tx_no_ack, .o_tx_flush, .o_len, .o_reuse_active,
        .o_ack_commit, .o_ack_pipe, .o_reg_addr, .o_reg_byte, .o_reg_wr, .o_reg_wdata);
    rcd_host host (.i_ref_clk(i_ref_clk), .i_spi_miso(o_spi_miso), .o_sck(i_spi_sck), .o_cs_n(i_spi_cs_n),
        .o_mosi(i_spi_mosi));

    // Clock of 25 ns period.
    always #12.5 i_ref_clk = ~i_ref_clk;

    // Radio side answers payload and register reads from the indices.
    always_comb begin
        i_rx_byte   = rx_base + {2'h0, o_rx_idx};
        i_reg_rdata = reg_base + {2'h0, o_reg_byte};
    end

    // Counts the one-cycle pulses and captures what qualifies them.
    always @(posedge i_ref_clk) begin
        if (o_tx_commit === 1'b1) begin
            n_tx++;
            c_len = o_len;
            c_na  = o_tx_no_ack;
        end
        if (o_ack_commit === 1'b1) begin
            n_ack++;
            c_pipe = o_ack_pipe;
        end
        if (o_reg_wr === 1'b1) begin
            n_reg++;
            c_wd = o_reg_wdata;
            c_ra = o_reg_addr;
        end
        n_rxp += (o_rx_pop === 1'b1);
        n_ftx += (o_tx_flush === 1'b1);
        n_frx += (o_rx_flush === 1'b1);
        n_oe  += (o_spi_miso_oe === 1'b1);
    end

    // ============================================================
    // Helpers.
    function automatic logic [7:0] rnd8();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Sends opcode op and m random data bytes; every frame shifts the status out first.
    task automatic frame(input logic [7:0] op, input int m);
        {n_tx, n_rxp, n_ftx, n_frx, n_ack, n_reg, n_oe} = '0;
        i_status = rnd8();
        pk[0] = op;
        for (int i = 1; i <= m; i++) pk[i] = rnd8();
        for (int i = 0; i <= m; i++) host.tx_buf[i] = pk[i];
        host.xfer(m + 1);
        chk(host.rx_buf[0], i_status, "status");
        // Select stays low for 48 cycles a byte plus 5; the output drive follows it one cycle late.
        chk(8'(n_oe - 48 * (m + 1)), 8'h05, "drive window");
    endtask

    task automatic pulse_sent();
        @(negedge i_ref_clk) i_ack_sent = 1'b1;
        @(negedge i_ref_clk) i_ack_sent = 1'b0;
    endtask

    // Bounded watchdog against a hang.
    initial begin
        repeat (100000) @(posedge i_ref_clk);
        n_fail++;
        $display("[ERR] %0t run did not finish", $time);
        results();
    end

    // ============================================================
    // Main sequence; no radio activity runs, so flush, repeat and register writes are legal.
    initial begin // Ordering kept by the host side.
        {i_ref_clk, i_arst_n, i_ack_sent, i_status, i_rx_width, rx_base, reg_base, i_stage_raddr} = '0;
        seed = 32'hD243;
        repeat (6) @(negedge i_ref_clk);
        i_arst_n = 1'b1;
        repeat (2) @(negedge i_ref_clk);
        // Transmit writes at both length limits and one random length, then the staged bytes.
        for (int j = 0; j < 3; j++) begin
            n = (j == 0) ? 1 : (j == 1) ? 32 : 2 + rnd8() % 30;
            frame(8'hA0, n);
            chk(8'(n_tx), 8'h01, "tx commit");
            chk({2'h0, c_len}, 8'(n), "tx length");
            chk({7'h00, c_na}, 8'h00, "ack wanted");
            for (int k = 0; k < n; k++) begin
                @(negedge i_ref_clk) i_stage_raddr = 5'(k);
                @(negedge i_ref_clk) chk(o_stage_rdata, pk[k + 1], "staged byte");
            end
        end
        frame(8'hB0, 1 + rnd8() % 32);
        chk(8'(n_tx), 8'h01, "no-ack commit");
        chk({7'h00, c_na}, 8'h01, "no-ack flag");
        // Repeat mode set, ended by a write, set again, ended by a flush.
        frame(8'hE3, 0);
        chk({7'h00, o_reuse_active}, 8'h01, "repeat on");
        chk(8'(n_tx), 8'h00, "repeat no commit");
        frame(8'hA0, 3);
        chk({7'h00, o_reuse_active}, 8'h00, "repeat off by write");
        frame(8'hE3, 0);
        frame(8'hE1, 0);
        chk({7'h00, o_reuse_active}, 8'h00, "repeat off by flush");
        chk(8'(n_ftx), 8'h01, "tx flush");
        frame(8'hE2, 0);
        chk(8'(n_frx + 2 * n_rxp), 8'h01, "rx flush");
        // Receive read of a random length, payload popped once.
        rx_base = rnd8();
        n = 1 + rnd8() % 32;
        frame(8'h61, n);
        for (int k = 0; k < n; k++) chk(host.rx_buf[k + 1], rx_base + 8'(k), "rx byte");
        chk(8'(n_rxp), 8'h01, "rx pop");
        i_rx_width = rnd8();
        frame(8'h60, 1);
        chk(host.rx_buf[1], i_rx_width, "width");
        // Idle, unknown opcode and invalid pipes leave no trace.
        foreach (pk[j]) if (j < 4) begin
            frame((j == 0) ? 8'hFF : (j == 1) ? 8'h50 : 8'hAC + 8'(j), 2);
            chk(8'(n_tx + n_ack + n_ftx + n_frx + n_rxp + n_reg), 8'h00, "no effect");
        end
        // Three pending acknowledge payloads accepted, the fourth refused until one is sent.
        for (int j = 0; j < 4; j++) begin
            frame(8'hA8, 2);
            chk(8'(n_ack), (j < 3) ? 8'h01 : 8'h00, "ack slots");
        end
        for (int p = 0; p < 6; p++) begin
            pulse_sent();
            frame(8'hA8 + 8'(p), 1 + rnd8() % 32);
            chk(8'(n_ack), 8'h01, "ack commit");
            chk({5'h00, c_pipe}, 8'(p), "ack pipe");
        end
        // Register write and read with a five-bit address.
        n = rnd8() % 32;
        frame(8'h20 + 8'(n), 1);
        chk(8'(n_reg), 8'h01, "reg write");
        chk({3'h0, c_ra}, 8'(n), "reg address");
        chk(c_wd, pk[1], "reg data");
        reg_base = rnd8();
        frame(8'(n), 1);
        chk(host.rx_buf[1], reg_base, "reg read");
        results();
    end
endmodule

`default_nettype wire
